// ### flag_block_params.svh
`ifndef FLAG_BLOCK_PARAMS_SVH
`define FLAG_BLOCK_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FLAGS_IDX 6'h16
`define CTRL_IDX 6'h17

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define PORT_CHANGE_BIT 7
`define TIMER_THREE_BIT 6
`define TIMER_TWO_BIT 5
`define TIMER_ONE_BIT 4
`define CAPTURE_TWO_BIT 3
`define CAPTURE_ONE_BIT 2
`define TRANSMIT_BIT 1
`define RECEIVE_BIT 0

// ----------------------------------------------------------------
// Control bit positions and reset values
// ----------------------------------------------------------------
`define MODE_SELECT_BIT 0
`define CASCADE_BIT 1
`define FLAG_RESET 1'h0
`define CTRL_RESET 2'h0
`define TRANSMIT_RESET 1'h1
`define RECEIVE_RESET 1'h0
`define TIMER_THREE_FULL 16'hffff

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### flag_block_pkg.sv
package flag_block_pkg;

  typedef enum logic [1:0] {
    SEL_FLAGS,
    SEL_CTRL,
    SEL_NONE
  } reg_sel_t;

  typedef struct packed {
    logic cascade;
    logic timer_mode_select;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] timer_three_count;
    logic [15:0] timer_three_period_pair;
    logic [7:0] timer_two_count;
    logic [7:0] timer_two_period;
    logic [7:0] timer_one_count;
    logic [7:0] timer_one_period;
  } timers_t;

endpackage : flag_block_pkg

// ### flag_bit.sv
`timescale 1ns/1ps
`include "flag_block_params.svh"

module flag_bit (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic set_event, // Source condition this cycle
  input wire logic wr_en, // Software write to the flag register
  input wire logic wr_value, // Value written by software
  output logic flag // Sticky request flag
);

  // Set beats a same-cycle software clear so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= `FLAG_RESET;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (wr_en) begin
      flag <= wr_value;
    end
  end

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
      set_event |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost its set");

endmodule : flag_bit

// ### rollover_detect.sv
`timescale 1ns/1ps

module rollover_detect #(
  parameter int WIDTH = 16
) (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] count, // Live timer count
  input wire logic [WIDTH-1:0] period, // Terminal value
  output logic hit // Count went from period to zero
);

  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= count;
    end
  end

  // A held count of zero fires only if period is zero: the previous count must match
  assign hit = (prev_reg == period) && (count == '0);

  property p_hit_needs_zero;
    @(posedge aclk) disable iff (!aresetn)
      hit |-> (count == '0) && ($past(count) == period);
  endproperty
  a_hit_needs_zero: assert property (p_hit_needs_zero)
    else $error("rollover seen without return to zero");

endmodule : rollover_detect

// ### peripheral_interrupt_flags_one.sv
`timescale 1ns/1ps
`include "flag_block_params.svh"

// Functional notes
// - Eight request flag bits, one for each peripheral source.
// - Flags set by their source regardless of enables or global disable.
// - Bit 7 sets while any monitored port input differs from its latch.
// - Mode select 1: third-timer flag sets on 16-bit overflow.
// - Mode select 0: third-timer flag sets on period-pair rollover to zero.
// - Second-timer flag sets when 8-bit count rolls from period to zero.
// - Receive flag is read-only and shows receive buffer holding data.
// - Transmit flag is read-only and shows transmit buffer empty.
module peripheral_interrupt_flags_one (
  input wire logic aclk, // Core clock, 200 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] awaddr, // Write address
  input wire logic [2:0] awprot, // Write protection, unused
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic [2:0] arprot, // Read protection, unused
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [7:0] change_monitored_port, // Port input levels
  input wire logic [7:0] port_latched, // Last latched port value
  input wire flag_block_pkg::timers_t timers, // Timer counts, periods
  input wire logic capture_one_event, // Capture on first pin
  input wire logic capture_two_event, // Capture on second pin
  input wire logic receive_buffer_full, // Receive buffer holds data
  input wire logic transmit_buffer_empty, // Transmit buffer empty
  output logic [7:0] request_flags, // Flag register contents
  output logic timer_mode_select, // Capture one on, period off
  output logic timer_cascade // First and second timers cascaded
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic flag_block_pkg::reg_sel_t decode(
    input logic [7:0] addr
  );
    if (addr[7:2] == `FLAGS_IDX) begin
      return flag_block_pkg::SEL_FLAGS;
    end else if (addr[7:2] == `CTRL_IDX) begin
      return flag_block_pkg::SEL_CTRL;
    end else begin
      return flag_block_pkg::SEL_NONE;
    end
  endfunction : decode

  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  flag_block_pkg::ctrl_t ctrl_reg;
  logic transmit_reg;
  logic receive_reg;
  logic [7:0] flag_q;

  wire aw_fire = awvalid && awready_reg;
  wire w_fire = wvalid && wready_reg;
  // Both halves held and no answer pending: the write lands now
  wire wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  wire flag_block_pkg::reg_sel_t wr_sel = decode(aw_addr_reg);
  wire flag_block_pkg::reg_sel_t rd_sel = decode(araddr);
  wire flags_wr =
    wr_fire && (wr_sel == flag_block_pkg::SEL_FLAGS) && wstrb_reg[0];
  wire ctrl_wr =
    wr_fire && (wr_sel == flag_block_pkg::SEL_CTRL) && wstrb_reg[0];
  wire [7:0] flags_view = {flag_q[7:2], transmit_reg, receive_reg};
  wire [31:0] rd_value =
    (rd_sel == flag_block_pkg::SEL_FLAGS) ? {24'h000000, flags_view} :
    (rd_sel == flag_block_pkg::SEL_CTRL) ? {30'h00000000, ctrl_reg} :
    32'h00000000;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_fire) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= awaddr;
      end else if (bvalid_reg && bready) begin
        awready_reg <= 1'b1;
      end
      if (w_fire) begin
        wready_reg <= 1'b0;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end else if (bvalid_reg && bready) begin
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == flag_block_pkg::SEL_NONE) ?
                   `RESP_SLVERR : `RESP_OKAY;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Reads have no side effect, so the data is captured with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= (rd_sel == flag_block_pkg::SEL_NONE) ?
                   `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg.timer_mode_select <= wdata_reg[`MODE_SELECT_BIT];
      ctrl_reg.cascade <= wdata_reg[`CASCADE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Source conditions
  // ----------------------------------------------------------------
  logic [7:0] set_vec;
  logic t1_hit;
  logic t2_hit;
  logic t3_hit;

  wire [15:0] t1_count = ctrl_reg.cascade ?
    {timers.timer_two_count, timers.timer_one_count} :
    {8'h00, timers.timer_one_count};
  wire [15:0] t1_period = ctrl_reg.cascade ?
    {timers.timer_two_period, timers.timer_one_period} :
    {8'h00, timers.timer_one_period};
  // Overflow is a rollover from all ones, so one detector serves both
  wire [15:0] t3_period = ctrl_reg.timer_mode_select ?
    `TIMER_THREE_FULL : timers.timer_three_period_pair;

  rollover_detect #(.WIDTH(16)) u_timer_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .count(t1_count),
    .period(t1_period),
    .hit(t1_hit)
  );

  rollover_detect #(.WIDTH(8)) u_timer_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .count(timers.timer_two_count),
    .period(timers.timer_two_period),
    .hit(t2_hit)
  );

  rollover_detect #(.WIDTH(16)) u_timer_three (
    .aclk(aclk),
    .aresetn(aresetn),
    .count(timers.timer_three_count),
    .period(t3_period),
    .hit(t3_hit)
  );

  // Mismatch is a level; the flag keeps setting until software fixes it
  assign set_vec[`PORT_CHANGE_BIT] =
    |(change_monitored_port ^ port_latched);
  assign set_vec[`TIMER_THREE_BIT] = t3_hit;
  assign set_vec[`TIMER_TWO_BIT] = t2_hit;
  assign set_vec[`TIMER_ONE_BIT] = t1_hit;
  assign set_vec[`CAPTURE_TWO_BIT] = capture_two_event;
  assign set_vec[`CAPTURE_ONE_BIT] = capture_one_event;
  assign set_vec[1:0] = 2'h0;
  assign flag_q[1:0] = 2'h0;

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  // No enable gates the sets: enables live outside this block
  genvar gi;
  generate
    for (gi = 2; gi < 8; gi++) begin : g_flag
      flag_bit u_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_event(set_vec[gi]),
        .wr_en(flags_wr),
        .wr_value(wdata_reg[gi]),
        .flag(flag_q[gi])
      );
    end
  endgenerate

  // Buffer states are mirrored; writes to these bits are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_reg <= `TRANSMIT_RESET;
      receive_reg <= `RECEIVE_RESET;
    end else begin
      transmit_reg <= transmit_buffer_empty;
      receive_reg <= receive_buffer_full;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign request_flags = flags_view;
  assign timer_mode_select = ctrl_reg.timer_mode_select;
  assign timer_cascade = ctrl_reg.cascade;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_port_change;
    (change_monitored_port != port_latched) |=> request_flags[7];
  endproperty
  a_port_change: assert property (p_port_change)
    else $error("port mismatch did not set bit 7");

  property p_t3_overflow;
    ctrl_reg.timer_mode_select &&
    $past(timers.timer_three_count) == 16'hffff &&
    timers.timer_three_count == 16'h0000 |=> request_flags[6];
  endproperty
  a_t3_overflow: assert property (p_t3_overflow)
    else $error("timer three overflow missed");

  property p_t3_period;
    !ctrl_reg.timer_mode_select &&
    $past(timers.timer_three_count) == timers.timer_three_period_pair &&
    timers.timer_three_count == 16'h0000 |=> request_flags[6];
  endproperty
  a_t3_period: assert property (p_t3_period)
    else $error("timer three period rollover missed");

  property p_t2_period;
    $past(timers.timer_two_count) == timers.timer_two_period &&
    timers.timer_two_count == 8'h00 |=> request_flags[5];
  endproperty
  a_t2_period: assert property (p_t2_period)
    else $error("timer two rollover missed");

  property p_t1_byte;
    !ctrl_reg.cascade && $past(aresetn) &&
    $past(timers.timer_one_count) == timers.timer_one_period &&
    timers.timer_one_count == 8'h00 |=> request_flags[4];
  endproperty
  a_t1_byte: assert property (p_t1_byte)
    else $error("timer one rollover missed");

  property p_t1_quiet;
    !t1_hit && !flags_wr && !request_flags[4] |=> !request_flags[4];
  endproperty
  a_t1_quiet: assert property (p_t1_quiet)
    else $error("timer one flag set without cause");

  property p_t1_cascade;
    ctrl_reg.cascade &&
    $past({timers.timer_two_count, timers.timer_one_count}) ==
    {timers.timer_two_period, timers.timer_one_period} &&
    {timers.timer_two_count, timers.timer_one_count} == 16'h0000
    |=> request_flags[4];
  endproperty
  a_t1_cascade: assert property (p_t1_cascade)
    else $error("cascaded rollover missed");

  // Each channel is checked on its own so single pulses exercise it
  property p_capture;
    (capture_one_event |=> request_flags[2]) and
    (capture_two_event |=> request_flags[3]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture event did not set its flag");

  property p_buffers;
    ##1 request_flags[0] == $past(receive_buffer_full) &&
        request_flags[1] == $past(transmit_buffer_empty);
  endproperty
  a_buffers: assert property (p_buffers)
    else $error("buffer flags do not follow buffer state");

  property p_clear_loses;
    flags_wr && !wdata_reg[3] && capture_two_event |=> request_flags[3];
  endproperty
  a_clear_loses: assert property (p_clear_loses)
    else $error("clear beat a same-cycle capture");

  c_write_flags: cover property (flags_wr);
  c_t3_overflow: cover property (ctrl_reg.timer_mode_select && t3_hit);
  c_cascade: cover property (ctrl_reg.cascade && t1_hit);
  c_read: cover property (rvalid_reg && rready && rdata_reg[7]);

endmodule : peripheral_interrupt_flags_one

// ### tb_peripheral_interrupt_flags_one.sv
`timescale 1ns/1ps
`include "flag_block_params.svh"

module tb_peripheral_interrupt_flags_one;
  localparam logic [7:0] FLAGS_ADDR = {`FLAGS_IDX, 2'h0};
  localparam logic [7:0] CTRL_ADDR = {`CTRL_IDX, 2'h0};
  localparam logic [7:0] HOLE_ADDR = 8'h60;
  localparam int LIMIT = 40;

  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [7:0] change_monitored_port;
  logic [7:0] port_latched;
  flag_block_pkg::timers_t timers;
  logic capture_one_event;
  logic capture_two_event;
  logic receive_buffer_full;
  logic transmit_buffer_empty;
  logic [7:0] request_flags;
  logic timer_mode_select;
  logic timer_cascade;
  int bad_count;
  int num_checks;

  peripheral_interrupt_flags_one u_peripheral_interrupt_flags_one (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .change_monitored_port(change_monitored_port),
    .port_latched(port_latched), .timers(timers),
    .capture_one_event(capture_one_event),
    .capture_two_event(capture_two_event),
    .receive_buffer_full(receive_buffer_full),
    .transmit_buffer_empty(transmit_buffer_empty),
    .request_flags(request_flags),
    .timer_mode_select(timer_mode_select),
    .timer_cascade(timer_cascade)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task hang(input int n);
    if (n >= LIMIT) begin
      bad_count++;
      $display("Bus handshake did not finish at %0t", $time);
      summarize();
    end
  endtask : hang

  // ----------------------------------------------------------------
  // Bus master tasks
  // ----------------------------------------------------------------
  task reg_write(input logic [7:0] addr, input logic [31:0] data,
                 input logic [3:0] strb, input logic [1:0] exp_resp);
    int n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= addr;
    wdata <= data;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < LIMIT) begin
      @(posedge aclk);
      n++;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < LIMIT) begin
      @(posedge aclk);
      n++;
    end
    hang(n);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, exp_resp});
  endtask : reg_write

  task read_expect(input logic [7:0] addr, input logic [31:0] exp_data,
                   input logic [1:0] exp_resp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Let at least one edge pass so the request is seen before release
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < LIMIT);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < LIMIT) begin
      @(posedge aclk);
      n++;
    end
    hang(n);
    rready <= 1'b0;
    check({30'h0, rresp}, {30'h0, exp_resp});
    if (exp_resp === `RESP_OKAY) check(rdata, exp_data);
  endtask : read_expect

  task expect_flags(input logic [7:0] exp);
    read_expect(FLAGS_ADDR, {24'h0, exp}, `RESP_OKAY);
    check({24'h0, request_flags}, {24'h0, exp});
  endtask : expect_flags

  task clear_flags;
    reg_write(FLAGS_ADDR, 32'h0, 4'hf, `RESP_OKAY);
  endtask : clear_flags

  // ----------------------------------------------------------------
  // Source stimulus
  // ----------------------------------------------------------------
  function automatic flag_block_pkg::timers_t mk(
      input logic [15:0] c3, input logic [15:0] p3, input logic [7:0] c2,
      input logic [7:0] p2, input logic [7:0] c1, input logic [7:0] p1);
    mk = {c3, p3, c2, p2, c1, p1};
  endfunction : mk

  // Counts go a then b; b leaves counts at zero, except timer two at 05 in the last roll, with nonzero periods
  task roll(input flag_block_pkg::timers_t a,
            input flag_block_pkg::timers_t b, input logic [7:0] exp);
    @(posedge aclk);
    timers <= a;
    @(posedge aclk);
    timers <= b;
    repeat (2) @(posedge aclk);
    expect_flags(exp | 8'h02);
    clear_flags();
  endtask : roll

  task pulse(input int which);
    @(posedge aclk);
    if (which == 1) capture_one_event <= 1'b1;
    else capture_two_event <= 1'b1;
    @(posedge aclk);
    capture_one_event <= 1'b0;
    capture_two_event <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    num_checks = 0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    change_monitored_port = 8'h5a;
    port_latched = 8'h5a;
    // Nonzero periods so idle zero counts never look like a rollover
    timers = mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80);
    capture_one_event = 1'b0;
    capture_two_event = 1'b0;
    receive_buffer_full = 1'b0;
    transmit_buffer_empty = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    expect_flags(8'h02);
    read_expect(CTRL_ADDR, 32'h0, `RESP_OKAY);
    receive_buffer_full <= 1'b1;
    transmit_buffer_empty <= 1'b0;
    repeat (2) @(posedge aclk);
    expect_flags(8'h01);
    reg_write(FLAGS_ADDR, 32'hff, 4'hf, `RESP_OKAY);
    expect_flags(8'hfd);
    clear_flags();
    expect_flags(8'h01);
    receive_buffer_full <= 1'b0;
    transmit_buffer_empty <= 1'b1;
    pulse(1);
    expect_flags(8'h06);
    pulse(2);
    expect_flags(8'h0e);
    reg_write(FLAGS_ADDR, 32'h0, 4'he, `RESP_OKAY);
    expect_flags(8'h0e);
    // Capture held through a clear: the set must win on bit 3
    capture_two_event <= 1'b1;
    clear_flags();
    capture_two_event <= 1'b0;
    expect_flags(8'h0a);
    clear_flags();
    expect_flags(8'h02);
    change_monitored_port <= 8'h5b;
    repeat (2) @(posedge aclk);
    expect_flags(8'h82);
    clear_flags();
    expect_flags(8'h82);
    change_monitored_port <= 8'h5a;
    clear_flags();
    expect_flags(8'h02);
    reg_write(HOLE_ADDR, 32'hff, 4'hf, `RESP_SLVERR);
    read_expect(HOLE_ADDR, 32'h0, `RESP_SLVERR);
    expect_flags(8'h02);
    roll(mk(16'h1234, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80),
         mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80), 8'h40);
    roll(mk(16'hffff, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80),
         mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80), 8'h00);
    roll(mk(16'h0, 16'h1234, 8'h10, 8'h10, 8'h0, 8'h80),
         mk(16'h0, 16'h1234, 8'h0, 8'h10, 8'h0, 8'h80), 8'h20);
    roll(mk(16'h0, 16'h1234, 8'h05, 8'h10, 8'h0, 8'h80),
         mk(16'h0, 16'h1234, 8'h0, 8'h10, 8'h0, 8'h80), 8'h00);
    roll(mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h33, 8'h33),
         mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h33), 8'h10);
    reg_write(CTRL_ADDR, 32'h1, 4'hf, `RESP_OKAY);
    read_expect(CTRL_ADDR, 32'h1, `RESP_OKAY);
    check({31'h0, timer_mode_select}, 32'h1);
    roll(mk(16'hffff, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80),
         mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80), 8'h40);
    roll(mk(16'h1234, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80),
         mk(16'h0, 16'h1234, 8'h0, 8'h80, 8'h0, 8'h80), 8'h00);
    reg_write(CTRL_ADDR, 32'h2, 4'hf, `RESP_OKAY);
    read_expect(CTRL_ADDR, 32'h2, `RESP_OKAY);
    check({31'h0, timer_cascade}, 32'h1);
    roll(mk(16'h0, 16'h1234, 8'h12, 8'h12, 8'h34, 8'h34),
         mk(16'h0, 16'h1234, 8'h0, 8'h12, 8'h0, 8'h34), 8'h30);
    roll(mk(16'h0, 16'h1234, 8'h05, 8'h12, 8'h34, 8'h34),
         mk(16'h0, 16'h1234, 8'h05, 8'h12, 8'h0, 8'h34), 8'h00);
    summarize();
  end
endmodule : tb_peripheral_interrupt_flags_one
